// [lvr_pkg.sv]
// Purpose: constants for the low-voltage detect and reset control block
// Assumes: 20 MHz system clock, byte-wide registers on a plain port
package lvr_pkg;
    // =========================================================
    // register offsets
    localparam logic [7:0] LVR_CTRL_OFS = 8'h00;
    localparam logic [7:0] LVR_STAT_OFS = 8'h01;
    localparam logic [7:0] LVR_CNT_OFS = 8'h02;
    localparam logic [7:0] LVR_CSTP_OFS = 8'h03;
    // =========================================================
    // field positions
    localparam int LVR_CTRL_DE = 7;
    localparam int LVR_CTRL_SEL = 3;
    localparam int LVR_CTRL_RE = 2;
    localparam int LVR_CTRL_UE = 0;
    localparam int LVR_STAT_REF = 3;
    localparam int LVR_CSTP_SB = 7;
    // =========================================================
    // reset values and masks
    localparam logic [7:0] LVR_CTRL_RST = 8'h00;
    localparam logic [7:0] LVR_STAT_RST = 8'h00;
    localparam logic [7:0] LVR_CSTP_RST = 8'hff;
    localparam logic [7:0] LVR_CNT_RST = 8'h00;
    localparam logic [7:0] LVR_CTRL_KEEP = 8'h8c;
    localparam logic [7:0] LVR_STAT_FLAGS = 8'h83;
    localparam logic [7:0] LVR_STAT_PLAIN = 8'h78;
    localparam logic [7:0] LVR_STAT_DROP = 8'h02;
    localparam logic [7:0] LVR_STAT_RISE = 8'h01;
    localparam logic [7:0] LVR_STAT_OVF = 8'h80;
    localparam logic [7:0] LVR_CSTP_RW = 8'h9f;
    localparam logic [7:0] LVR_CSTP_FIXED = 8'h60;
    // =========================================================
    // timing
    localparam int LVR_CLK_MHZ = 20;
    localparam int LVR_PRESCALE_CYCLES = 131072;
    localparam logic [1:0] LVR_DIV_LAST = 2'h3;
    localparam logic [7:0] LVR_CNT_LAST = 8'hff;
    localparam int LVR_FILTER_NS = 100;
    localparam int LVR_FILTER_CYC = (LVR_FILTER_NS * LVR_CLK_MHZ + 999) / 1000;
endpackage

// [lvr_sync2.sv]
// Purpose: two-stage synchroniser for asynchronous comparator levels
// Assumes: inputs are slow levels, no pulse capture needed
// Notes: the first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module lvr_sync2 #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } lvr_sync_s;
    lvr_sync_s st_reg;
    lvr_sync_s st_next;

    initial
    begin
        if (WIDTH < 1) $error("lvr_sync2: WIDTH must be at least 1");
    end

    // =========================================================
    // two flip-flop stages
    always_comb
    begin
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign dout = st_reg.s2;
endmodule // lvr_sync2
`default_nettype wire

// [lvr_pin_filter.sv]
// Purpose: glitch filter for the active-low reset pin
// Assumes: pin sampled as synchronous to the clock
// Notes: a new level must hold CYCLES clocks before it passes
`timescale 1ns/10ps
`default_nettype none
module lvr_pin_filter #(
    parameter int CYCLES = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_n,
    output logic level_n
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    typedef struct packed {
        logic level;
        logic [CW-1:0] cnt;
    } lvr_filt_s;
    lvr_filt_s st_reg;
    lvr_filt_s st_next;

    initial
    begin
        if (CYCLES < 1) $error("lvr_pin_filter: CYCLES must be at least 1");
    end

    // =========================================================
    // a short excursion restarts the count, so glitches die out
    always_comb
    begin
        st_next = st_reg;
        if (pin_n == st_reg.level)
            st_next.cnt = '0;
        else if (st_reg.cnt == LAST)
        begin
            st_next.level = pin_n;
            st_next.cnt = '0;
        end
        else
            st_next.cnt = st_reg.cnt + CW'(1);
    end

    // level starts low so the chip stays held until the pin is seen high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign level_n = st_reg.level;
endmodule // lvr_pin_filter
`default_nettype wire

// [lvr_ctrl.sv]
// Purpose: reset sequencing, detection flags and registers
// Assumes: comparator inputs are asynchronous levels, active high
// Notes: SYS_RST is the power-on reset; WDT_RST is a watchdog pulse
`timescale 1ns/10ps
`default_nettype none
module lvr_ctrl #(
    parameter int PRESCALE_CYCLES = lvr_pkg::LVR_PRESCALE_CYCLES
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic WDT_RST,
    input wire logic RESET_PIN_N,
    input wire logic CMP_DROP,
    input wire logic CMP_RISE,
    input wire logic CMP_RESET,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic CHIP_RESET_N,
    output logic DETECT_RESET_N,
    output logic DETECT_ON,
    output logic REF_EXT_SELECT,
    output logic LEVEL_HIGH_SELECT
);
    import lvr_pkg::*;

    localparam int PW = $clog2(PRESCALE_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE_CYCLES - 1);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] stat;
        logic [7:0] cstp;
        logic [7:0] cnt;
        logic cnt_done;
        logic [1:0] div;
        logic [7:0] arm;
        logic rise_armed;
        logic drop_prev;
        logic [PW-1:0] pre;
        logic in_reset;
        logic full_cause;
        logic det_rst_n;
        logic [7:0] rdata;
    } lvr_state_s;

    lvr_state_s st_reg;
    lvr_state_s st_next;
    logic [2:0] cmp_sync;
    logic pin_level_n;
    logic drop_s;
    logic rise_s;
    logic rst_s;
    logic det_on;
    logic lvd_trip;
    logic full_hold;
    logic drop_set;
    logic rise_set;
    logic ovf_set;

    initial
    begin
        if (PRESCALE_CYCLES < 2)
            $error("lvr_ctrl: PRESCALE_CYCLES must be at least 2");
    end

    // =========================================================
    // read multiplexer, unmapped offsets read zero
    function automatic logic [7:0] rd_mux(
        input logic [7:0] addr,
        input lvr_state_s s
    );
        logic [7:0] r;
        r = 8'h00;
        unique case (addr)
            LVR_CTRL_OFS: r = s.ctrl;
            LVR_STAT_OFS: r = s.stat;
            LVR_CNT_OFS: r = s.cnt;
            LVR_CSTP_OFS: r = s.cstp;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // =========================================================
    // comparator synchronisers and pin filter
    lvr_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .din({CMP_RESET, CMP_RISE, CMP_DROP}),
        .dout(cmp_sync)
    );

    lvr_pin_filter #(
        .CYCLES(LVR_FILTER_CYC)
    ) u_filt (
        .clk(CLK),
        .rst(SYS_RST),
        .pin_n(RESET_PIN_N),
        .level_n(pin_level_n)
    );

    assign drop_s = cmp_sync[0];
    assign rise_s = cmp_sync[1];
    assign rst_s = cmp_sync[2];

    // =========================================================
    // detection gating and event decode
    // standby from the clock-stop bit freezes the counter, the flags and the detector reset
    assign det_on = st_reg.ctrl[LVR_CTRL_DE] & st_reg.cstp[LVR_CSTP_SB];
    assign lvd_trip = det_on & st_reg.ctrl[LVR_CTRL_RE] & rst_s;
    assign full_hold = ~pin_level_n | WDT_RST;
    assign drop_set = det_on & drop_s & ~st_reg.drop_prev;
    // rise only counts when not still under the drop level
    assign rise_set = st_reg.rise_armed & det_on & rise_s & ~drop_s
        & st_reg.ctrl[LVR_CTRL_UE];
    assign ovf_set = det_on & ~st_reg.cnt_done & (st_reg.div == LVR_DIV_LAST)
        & (st_reg.cnt == LVR_CNT_LAST);

    // =========================================================
    // next-state logic
    always_comb
    begin
        st_next = st_reg;
        st_next.rdata = 8'h00;
        st_next.det_rst_n = ~lvd_trip;

        // reset prescaler: held while any source is active, then counts
        if (full_hold | lvd_trip)
        begin
            st_next.pre = '0;
            st_next.in_reset = 1'b1;
            // a pin or watchdog reset upgrades a detector reset to full
            if (full_hold)
                st_next.full_cause = 1'b1;
            else if (!st_reg.in_reset)
                st_next.full_cause = 1'b0;
        end
        else if (st_reg.in_reset)
        begin
            if (st_reg.pre == PRE_LAST)
                st_next.in_reset = 1'b0;
            else
                st_next.pre = st_reg.pre + PW'(1);
        end

        if (st_reg.in_reset)
        begin
            // internal reset: detector cause keeps its own control bits
            if (st_reg.full_cause)
            begin
                st_next.ctrl = LVR_CTRL_RST;
                st_next.stat = LVR_STAT_RST;
                st_next.cstp = LVR_CSTP_RST;
            end
            else
            begin
                st_next.ctrl = st_reg.ctrl & LVR_CTRL_KEEP;
                st_next.stat = st_reg.stat & ~LVR_STAT_FLAGS;
            end
            st_next.cnt = LVR_CNT_RST;
            st_next.cnt_done = 1'b0;
            st_next.div = '0;
            st_next.arm = 8'h00;
            st_next.rise_armed = 1'b0;
            st_next.drop_prev = drop_s;
        end
        else
        begin
            // stabilisation counter on the divide-by-four tick
            if (!st_reg.ctrl[LVR_CTRL_DE])
            begin
                st_next.cnt = LVR_CNT_RST;
                st_next.cnt_done = 1'b0;
                st_next.div = '0;
            end
            else if (det_on && !st_reg.cnt_done)
            begin
                st_next.div = st_reg.div + 2'h1;
                if (st_reg.div == LVR_DIV_LAST)
                    st_next.cnt = st_reg.cnt + 8'h01;
                if (ovf_set)
                    st_next.cnt_done = 1'b1;
            end

            // rise is armed by a drop and disarmed by recovery or reset level
            st_next.drop_prev = drop_s;
            if (drop_set)
                st_next.rise_armed = 1'b1;
            else if ((rise_s && !drop_s) || rst_s)
                st_next.rise_armed = 1'b0;

            // register writes
            if (WR)
            begin
                unique case (ADDR)
                    LVR_CTRL_OFS: st_next.ctrl = WDATA;
                    LVR_STAT_OFS:
                    begin
                        // bit 2 is outside both masks, so it stays zero
                        st_next.stat = (st_reg.stat & ~LVR_STAT_PLAIN)
                            | (WDATA & LVR_STAT_PLAIN);
                        // a zero clears only a flag that was read as one
                        st_next.stat = st_next.stat
                            & ~(st_reg.arm & ~WDATA & LVR_STAT_FLAGS);
                        st_next.arm = 8'h00;
                    end
                    LVR_CSTP_OFS:
                        st_next.cstp = (WDATA & LVR_CSTP_RW) | LVR_CSTP_FIXED;
                    default:
                    begin
                        st_next.ctrl = st_reg.ctrl;
                    end
                endcase
            end

            // register reads, data stand in the following cycle
            if (RD)
            begin
                st_next.rdata = rd_mux(ADDR, st_reg);
                if (ADDR == LVR_STAT_OFS)
                    st_next.arm = st_reg.arm
                        | (st_reg.stat & LVR_STAT_FLAGS);
            end

            // hardware sets win over a same-cycle software clear
            if (drop_set)
                st_next.stat = st_next.stat | LVR_STAT_DROP;
            if (rise_set)
                st_next.stat = st_next.stat | LVR_STAT_RISE;
            if (ovf_set)
                st_next.stat = st_next.stat | LVR_STAT_OVF;
        end
    end

    // =========================================================
    // state register, power-on starts a full reset count
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            st_reg <= '0;
            st_reg.ctrl <= LVR_CTRL_RST;
            st_reg.stat <= LVR_STAT_RST;
            st_reg.cstp <= LVR_CSTP_RST;
            st_reg.cnt <= LVR_CNT_RST;
            st_reg.in_reset <= 1'b1;
            st_reg.full_cause <= 1'b1;
            st_reg.det_rst_n <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // =========================================================
    // outputs
    assign RDATA = st_reg.rdata;
    assign CHIP_RESET_N = ~st_reg.in_reset;
    assign DETECT_RESET_N = st_reg.det_rst_n;
    assign DETECT_ON = det_on;
    assign REF_EXT_SELECT = st_reg.stat[LVR_STAT_REF];
    assign LEVEL_HIGH_SELECT = st_reg.ctrl[LVR_CTRL_SEL];
endmodule // lvr_ctrl
`default_nettype wire

// [lvr_ctrl_props.sv]
// Purpose: port-level assertions for the reset control block
// Assumes: single clock CLK, SYS_RST asynchronous active high
// Notes: low_cnt mirrors the prescaler from outside the block
`timescale 1ns/10ps
`default_nettype none
module lvr_ctrl_props #(
    parameter int PRESCALE_CYCLES = 16
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic WDT_RST,
    input wire logic RESET_PIN_N,
    input wire logic CMP_RESET,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic CHIP_RESET_N,
    input wire logic DETECT_RESET_N,
    input wire logic DETECT_ON,
    input wire logic REF_EXT_SELECT,
    input wire logic LEVEL_HIGH_SELECT
);
    import lvr_pkg::*;
    // release may trail the count by the filter and sync stages
    localparam int SLACK = 12;
    int low_cnt;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    // ==========
    // helper: cycles in reset since the last cause went away
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            low_cnt <= 0;
        else if (CHIP_RESET_N || !RESET_PIN_N || WDT_RST
                 || (CMP_RESET && !DETECT_RESET_N))
            low_cnt <= 0;
        else
            low_cnt <= low_cnt + 1;
    end
    // ==========
    // requests the block takes
    sequence s_wr(logic [7:0] ofs);
        WR && CHIP_RESET_N && !WDT_RST && ADDR == ofs;
    endsequence
    sequence s_rd(logic [7:0] ofs);
        RD && CHIP_RESET_N && ADDR == ofs;
    endsequence
    property p_bit2_zero;
        s_rd(LVR_STAT_OFS) |=> !RDATA[2];
    endproperty
    a_bit2_zero: assert property (p_bit2_zero)
        else $error("status bit 2 read as one");
    property p_ref_sel;
        s_wr(LVR_STAT_OFS) |=> REF_EXT_SELECT == $past(WDATA[3]);
    endproperty
    a_ref_sel: assert property (p_ref_sel)
        else $error("reference select not taken");
    property p_level_sel;
        s_wr(LVR_CTRL_OFS) |=> LEVEL_HIGH_SELECT == $past(WDATA[3]);
    endproperty
    a_level_sel: assert property (p_level_sel)
        else $error("level select not taken");
    property p_detect_off;
        s_wr(LVR_CTRL_OFS) ##0 !WDATA[7] |=> !DETECT_ON;
    endproperty
    a_detect_off: assert property (p_detect_off)
        else $error("detection still on");
    property p_standby;
        s_wr(LVR_CSTP_OFS) ##0 !WDATA[7] |=> !DETECT_ON;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby ignored");
    // detector reset follows a synced comparator, chip reset with it
    property p_det_cause;
        $fell(DETECT_RESET_N) |-> !CHIP_RESET_N && $past(CMP_RESET, 2);
    endproperty
    a_det_cause: assert property (p_det_cause)
        else $error("detector reset without cause");
    property p_rel_early;
        $rose(CHIP_RESET_N) |-> low_cnt >= PRESCALE_CYCLES - 1;
    endproperty
    a_rel_early: assert property (p_rel_early)
        else $error("reset released early");
    property p_rel_late;
        !CHIP_RESET_N |-> low_cnt < PRESCALE_CYCLES + SLACK;
    endproperty
    a_rel_late: assert property (p_rel_late)
        else $error("reset released late");
    property p_keep_level;
        !DETECT_RESET_N && RESET_PIN_N && !WDT_RST
            |=> $stable(LEVEL_HIGH_SELECT) && DETECT_ON;
    endproperty
    a_keep_level: assert property (p_keep_level)
        else $error("detector reset lost control bits");
endmodule // lvr_ctrl_props
`default_nettype wire

// [lvr_analog_model.sv]
// Purpose: supply comparators and reset pin seen by the block
// Assumes: supply given in tenths of a volt
// Notes: comparator outputs move 3 ns after the supply, never on an edge; the pin follows pin_drive_n at once
`timescale 1ns/10ps
`default_nettype none
module lvr_analog_model #(
    parameter logic [7:0] DROP_DV = 8'h25,
    parameter logic [7:0] RISE_DV = 8'h28,
    parameter logic [7:0] RST_LO_DV = 8'h17,
    parameter logic [7:0] RST_HI_DV = 8'h21
) (
    input wire logic [7:0] supply_dv,
    input wire logic level_high,
    input wire logic pin_drive_n,
    output logic cmp_drop,
    output logic cmp_rise,
    output logic cmp_reset,
    output logic reset_pin_n
);
    // ==========
    // comparators are asynchronous to the clock
    assign #3 cmp_drop = supply_dv < DROP_DV;
    assign #3 cmp_rise = supply_dv > RISE_DV;
    // threshold follows the level select output
    assign #3 cmp_reset = supply_dv < (level_high ? RST_HI_DV : RST_LO_DV);
    // pin has a pull-up, so released means high
    assign reset_pin_n = pin_drive_n ? 1'b1 : 1'b0;
endmodule // lvr_analog_model
`default_nettype wire

// [lvr_ctrl_test.sv]
// Purpose: self-checking bench for the reset control block
// Assumes: 20 MHz clock, short prescale to keep the run short
// Notes: supply and pin come from the analog model
`timescale 1ns/10ps
`default_nettype none
module lvr_ctrl_test;
    import lvr_pkg::*;
    localparam int PRESCALE = 16;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wdt_rst = 1'b0;
    logic pin_drive_n = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] supply_dv = 8'h32;
    logic cmp_drop, cmp_rise, cmp_reset, pin_n;
    logic [7:0] rdata;
    logic chip_rst_n, det_rst_n, det_on, ref_ext, lvl_high;
    int fails = 0;
    int n_checks = 0;
    // 50 ns period
    always #25 clk = ~clk;
    lvr_analog_model i_lvr_analog_model (.supply_dv(supply_dv),
        .level_high(lvl_high), .pin_drive_n(pin_drive_n),
        .cmp_drop(cmp_drop), .cmp_rise(cmp_rise), .cmp_reset(cmp_reset),
        .reset_pin_n(pin_n));
    lvr_ctrl #(.PRESCALE_CYCLES(PRESCALE)) i_lvr_ctrl (.CLK(clk),
        .SYS_RST(sys_rst), .WDT_RST(wdt_rst), .RESET_PIN_N(pin_n),
        .CMP_DROP(cmp_drop), .CMP_RISE(cmp_rise), .CMP_RESET(cmp_reset),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CHIP_RESET_N(chip_rst_n), .DETECT_RESET_N(det_rst_n),
        .DETECT_ON(det_on), .REF_EXT_SELECT(ref_ext),
        .LEVEL_HIGH_SELECT(lvl_high));
    // ==========
    // compares and bus tasks
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_min(input int got, input int lim);
        n_checks++;
        if (got < lim)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h min=%h", $time, got, lim);
        end
    endtask
    // a wait that used up its bound ends the run
    task automatic bound(input int n, input int lim);
        if (n >= lim)
        begin
            fails++;
            wrap_up();
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check8(rdata, e);
    endtask
    task automatic wait_up(output int n);
        for (n = 0; n < 2000 && chip_rst_n !== 1'b1; n++) @(posedge clk);
        bound(n, 2000);
        @(negedge clk);
    endtask
    // ==========
    // scenarios
    task automatic t_power_on();
        int n;
        wait_up(n);
        check_min(n, PRESCALE);
        rd_chk(LVR_CTRL_OFS, 8'h00);
        rd_chk(LVR_CNT_OFS, 8'h00);
        rd_chk(LVR_CSTP_OFS, 8'hff);
        check8({7'h00, det_on}, 8'h00);
        $display("power_on done");
    endtask
    task automatic t_status();
        wr_reg(LVR_STAT_OFS, 8'h7c);
        rd_chk(LVR_STAT_OFS, 8'h78);
        check8({7'h00, ref_ext}, 8'h01);
        wr_reg(LVR_STAT_OFS, 8'h00);
        check8({7'h00, ref_ext}, 8'h00);
        wr_reg(8'h04, 8'hff);
        rd_chk(8'h04, 8'h00);
        $display("status done");
    endtask
    task automatic t_counter();
        wr_reg(LVR_CTRL_OFS, 8'h80);
        check8({7'h00, det_on}, 8'h01);
        // overflow needs 256 ticks of four clocks
        repeat (1000) @(posedge clk);
        rd_chk(LVR_STAT_OFS, 8'h00);
        repeat (40) @(posedge clk);
        rd_chk(LVR_STAT_OFS, 8'h80);
        wr_reg(LVR_CNT_OFS, 8'h55);
        rd_chk(LVR_CNT_OFS, 8'h00);
        wr_reg(LVR_STAT_OFS, 8'h80);
        wr_reg(LVR_STAT_OFS, 8'h00);
        rd_chk(LVR_STAT_OFS, 8'h80);
        wr_reg(LVR_STAT_OFS, 8'h00);
        rd_chk(LVR_STAT_OFS, 8'h00);
        $display("counter done");
    endtask
    task automatic t_drop_rise();
        wr_reg(LVR_CTRL_OFS, 8'h81);
        supply_dv = 8'h23;
        repeat (8) @(posedge clk);
        rd_chk(LVR_STAT_OFS, 8'h02);
        supply_dv = 8'h2d;
        repeat (8) @(posedge clk);
        rd_chk(LVR_STAT_OFS, 8'h03);
        wr_reg(LVR_STAT_OFS, 8'h01);
        rd_chk(LVR_STAT_OFS, 8'h01);
        wr_reg(LVR_STAT_OFS, 8'h00);
        rd_chk(LVR_STAT_OFS, 8'h00);
        $display("drop_rise done");
    endtask
    task automatic t_standby();
        wr_reg(LVR_CTRL_OFS, 8'h80);
        wr_reg(LVR_CSTP_OFS, 8'h00);
        rd_chk(LVR_CSTP_OFS, 8'h60);
        check8({7'h00, det_on}, 8'h00);
        supply_dv = 8'h23;
        repeat (8) @(posedge clk);
        rd_chk(LVR_STAT_OFS, 8'h00);
        supply_dv = 8'h32;
        wr_reg(LVR_CSTP_OFS, 8'hff);
        $display("standby done");
    endtask
    task automatic t_det_reset();
        int n;
        wr_reg(LVR_CTRL_OFS, 8'h8c);
        check8({7'h00, lvl_high}, 8'h01);
        supply_dv = 8'h1e;
        for (n = 0; n < 20 && det_rst_n !== 1'b0; n++) @(posedge clk);
        bound(n, 20);
        @(negedge clk);
        check8({6'h00, det_rst_n, chip_rst_n}, 8'h00);
        supply_dv = 8'h32;
        wait_up(n);
        check_min(n, PRESCALE);
        rd_chk(LVR_CTRL_OFS, 8'h8c);
        rd_chk(LVR_STAT_OFS, 8'h00);
        wr_reg(LVR_CTRL_OFS, 8'h88);
        wr_reg(LVR_CTRL_OFS, 8'h00);
        $display("det_reset done");
    endtask
    task automatic t_pin_wdt();
        int n;
        // one cycle low is 50 ns, shorter than the filter
        @(posedge clk);
        pin_drive_n <= 1'b0;
        @(posedge clk);
        pin_drive_n <= 1'b1;
        repeat (4) @(posedge clk);
        // look off the edge so the registered level has settled
        @(negedge clk);
        check8({7'h00, chip_rst_n}, 8'h01);
        wr_reg(LVR_CTRL_OFS, 8'h8c);
        @(posedge clk);
        pin_drive_n <= 1'b0;
        repeat (4) @(posedge clk);
        pin_drive_n <= 1'b1;
        @(negedge clk);
        check8({7'h00, chip_rst_n}, 8'h00);
        wait_up(n);
        check_min(n, PRESCALE);
        rd_chk(LVR_CTRL_OFS, 8'h00);
        wr_reg(LVR_CTRL_OFS, 8'h8c);
        @(posedge clk);
        wdt_rst <= 1'b1;
        @(posedge clk);
        wdt_rst <= 1'b0;
        @(negedge clk);
        wait_up(n);
        rd_chk(LVR_CTRL_OFS, 8'h00);
        $display("pin_wdt done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_power_on();
        t_status();
        t_counter();
        t_drop_rise();
        t_standby();
        t_det_reset();
        t_pin_wdt();
        wrap_up();
    end
endmodule // lvr_ctrl_test
bind lvr_ctrl lvr_ctrl_props #(.PRESCALE_CYCLES(PRESCALE_CYCLES))
    i_lvr_ctrl_props (.CLK(CLK), .SYS_RST(SYS_RST), .WDT_RST(WDT_RST),
    .RESET_PIN_N(RESET_PIN_N), .CMP_RESET(CMP_RESET), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CHIP_RESET_N(CHIP_RESET_N), .DETECT_RESET_N(DETECT_RESET_N),
    .DETECT_ON(DETECT_ON), .REF_EXT_SELECT(REF_EXT_SELECT),
    .LEVEL_HIGH_SELECT(LEVEL_HIGH_SELECT));
`default_nettype wire
